// ===== core/apb_port.sv
// APB slave front end with zero wait states.
// Assumes the register side answers rdata combinationally from addr.
module apb_port
   import exec_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [APB_AW-1:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   reg_if.bus rg
);

   // All state: the read data captured in the setup cycle.
   typedef struct packed {
      logic [31:0] prdata;
   } port_state_t;

   port_state_t cur_reg;
   port_state_t cur_next;

   // Read data is sampled at the end of setup so PRDATA is a flop.
   always_comb
   begin
      cur_next = cur_reg;
      if (psel_i && !penable_i && !pwrite_i)
      begin
         cur_next.prdata = reg_mapped(paddr_i) ? rg.rdata : 32'h0000_0000;
      end
   end

   // State register.
   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         cur_reg <= '0;
      end
      else
      begin
         cur_reg <= cur_next;
      end
   end

   // Every access completes in its first access cycle.
   assign pready_o = 1'b1;
   assign pslverr_o = psel_i && penable_i && !reg_mapped(paddr_i);
   assign prdata_o = cur_reg.prdata;
   assign rg.wr = psel_i && penable_i && pwrite_i && reg_mapped(paddr_i);
   assign rg.addr = paddr_i;
   assign rg.wdata = pwdata_i;

endmodule : apb_port

// ===== core/branch_move_return_exec.sv
// Executor for long call and jump, immediate load, file moves, no-op
// and return with literal, issued one instruction at a time over APB.
// Assumes one 100 MHz clock, synchronous active-low reset, APB master.
//
// Function
// - call_long pushes current PC plus one.
// - call_long loads 10-bit target, two cycles.
// - jump_long loads 10-bit target, stack untouched, two cycles.
// - call_long raises stack pointer by one.
// - load_immediate_acc loads accumulator, flags kept, one cycle.
// - store_acc_to_file copies accumulator to register, one cycle.
// - move_file sends register to accumulator or back.
// - move_file sets zero flag from moved value.
// - no-op only advances PC, one cycle.
// - return_with_literal loads accumulator from literal, PC from stack.
// - return_with_literal sets global interrupt enable.
// - return_with_literal lowers stack pointer by one.
module branch_move_return_exec
   import exec_pkg::*;
(
   input wire logic CLK_I,
   input wire logic RST_N_I,
   input wire logic PSEL_I,
   input wire logic PENABLE_I,
   input wire logic PWRITE_I,
   input wire logic [APB_AW-1:0] PADDR_I,
   input wire logic [31:0] PWDATA_I,
   output logic [31:0] PRDATA_O,
   output logic PREADY_O,
   output logic PSLVERR_O,
   output logic [PC_W-1:0] PC_O,
   output logic [DATA_W-1:0] ACCUMULATOR_O,
   output logic ZERO_O,
   output logic GLOBAL_INTERRUPT_ENABLE_O,
   output logic BUSY_O
);

   // -------------------------------------------------------------------
   // State
   // -------------------------------------------------------------------

   // One decoded instruction: opcode, destination bit and operand.
   typedef struct packed {
      op_t op;               // Operation.
      logic dest;            // Destination select for move_file.
      logic [9:0] arg;       // Target, immediate or register address.
   } instr_t;

   // All state of the executor in one record.
   typedef struct packed {
      exec_state_t st;                    // Sequence position.
      instr_t cur;                        // Instruction under execution.
      logic pf_valid;                     // Prefetch slot is full.
      instr_t pf;                         // Prefetched instruction.
      logic discard;                      // Sticky: a prefetch was dropped.
      logic [PC_W-1:0] pc;                // Program counter.
      logic [DATA_W-1:0] accumulator;     // Accumulator.
      logic zero;                         // Zero flag.
      logic global_interrupt_enable;      // Global interrupt enable.
      logic [FILE_AW-1:0] faddr;          // Software window pointer.
      logic [FILE_N-1:0][DATA_W-1:0] file; // Data registers.
   } core_state_t;

   core_state_t core_reg;
   core_state_t core_next;

   // -------------------------------------------------------------------
   // Helpers
   // -------------------------------------------------------------------

   reg_if rg ();          // Register strobes from the APB front end.
   stack_if stk ();       // Return stack port.

   // Unpack a written word into an instruction.
   function automatic instr_t decode(input logic [31:0] w);
      instr_t r;
      r.op = op_t'(w[INSTR_OP_LSB +: 3]);
      r.dest = w[INSTR_DEST_BIT];
      r.arg = w[9:0];
      return r;
   endfunction : decode

   // Bus front end: decode, strobes and registered read data.
   apb_port u_apb_port (
      .clk_i(CLK_I),
      .rst_n_i(RST_N_I),
      .psel_i(PSEL_I),
      .penable_i(PENABLE_I),
      .pwrite_i(PWRITE_I),
      .paddr_i(PADDR_I),
      .pwdata_i(PWDATA_I),
      .prdata_o(PRDATA_O),
      .pready_o(PREADY_O),
      .pslverr_o(PSLVERR_O),
      .rg(rg.bus)
   );

   // Return stack, owned by its own module.
   return_stack u_return_stack (
      .clk_i(CLK_I),
      .rst_n_i(RST_N_I),
      .st(stk.owner)
   );

   // Scratch values for the next-state process.
   logic [DATA_W-1:0] moved;       // Value read by move_file.
   logic [FILE_AW-1:0] fsel;       // Register addressed by the instruction.
   logic [PC_W-1:0] pc_inc;        // Address of the following instruction.
   logic instr_wr;                 // Software issues an instruction.

   // -------------------------------------------------------------------
   // Next-state logic
   // -------------------------------------------------------------------

   // Register writes come first, then execution, then instruction issue.  Where a
   // register write and execution touch the same bit, execution is applied later so it wins.
   always_comb
   begin
      core_next = core_reg;
      fsel = core_reg.cur.arg[FILE_AW-1:0];
      moved = core_reg.file[fsel];
      pc_inc = core_reg.pc + 10'h001;
      instr_wr = rg.wr && (rg.addr == OFF_INSTR);
      stk.push = 1'b0;
      stk.pop = 1'b0;
      stk.push_pc = pc_inc;

      // Software writes that do not start execution.
      if (rg.wr)
      begin
         unique case (rg.addr)
            OFF_PC:
            begin
               // The PC may only be set while nothing executes.
               if (core_reg.st == ST_IDLE)
               begin
                  core_next.pc = rg.wdata[PC_W-1:0];
               end
            end
            OFF_ACCUM:
            begin
               // Read-only from software.
            end
            OFF_FLAGS:
            begin
               // Zero and interrupt enable may be written; discard is
               // cleared by writing one.
               core_next.zero = rg.wdata[FLAG_Z_BIT];
               core_next.global_interrupt_enable = rg.wdata[FLAG_INT_EN_BIT];
               if (rg.wdata[FLAG_DISC_BIT])
               begin
                  core_next.discard = 1'b0;
               end
            end
            OFF_FADDR:
            begin
               core_next.faddr = rg.wdata[FILE_AW-1:0];
            end
            OFF_FDATA:
            begin
               core_next.file[core_reg.faddr] = rg.wdata[DATA_W-1:0];
            end
            default:
            begin
               // Instruction issue is handled below.
            end
         endcase
      end

      // Sequence and instruction effects.
      unique case (core_reg.st)
         ST_IDLE:
         begin
            // Waiting for software to issue an instruction.
         end
         ST_EXEC:
         begin
            unique case (core_reg.cur.op)
               OP_CALL_LONG:
               begin
                  stk.push = 1'b1;
                  core_next.pc[9:0] = core_reg.cur.arg;
               end
               OP_JUMP_LONG:
               begin
                  // Stack untouched; only the low ten bits are loaded.
                  core_next.pc[9:0] = core_reg.cur.arg;
               end
               OP_LOAD_IMMEDIATE_ACC:
               begin
                  // Flags are deliberately left as they were.
                  core_next.accumulator = core_reg.cur.arg[7:0];
                  core_next.pc = pc_inc;
               end
               OP_STORE_ACC_TO_FILE:
               begin
                  core_next.file[fsel] = core_reg.accumulator;
                  core_next.pc = pc_inc;
               end
               OP_MOVE_FILE:
               begin
                  // Moving a register onto itself is a cheap zero test.
                  if (core_reg.cur.dest)
                  begin
                     core_next.file[fsel] = moved;
                  end
                  else
                  begin
                     core_next.accumulator = moved;
                  end
                  core_next.zero = (moved == 8'h00);
                  core_next.pc = pc_inc;
               end
               OP_RETURN_WITH_LITERAL:
               begin
                  core_next.accumulator = core_reg.cur.arg[7:0];
                  core_next.pc = stk.top_pc;
                  stk.pop = 1'b1;
                  core_next.global_interrupt_enable = 1'b1;
               end
               default:
               begin
                  // No-op and the unused code only step the PC.
                  core_next.pc = pc_inc;
               end
            endcase

            // Choose what follows this instruction.
            if (is_two_cycle(core_reg.cur.op))
            begin
               // The held prefetch is stale: drop it and idle one cycle.
               core_next.st = ST_FLUSH;
               if (core_reg.pf_valid)
               begin
                  core_next.pf_valid = 1'b0;
                  core_next.discard = 1'b1;
               end
            end
            else if (core_reg.pf_valid)
            begin
               core_next.cur = core_reg.pf;
               core_next.pf_valid = 1'b0;
            end
            else
            begin
               core_next.st = ST_IDLE;
            end
         end
         ST_FLUSH:
         begin
            // The idle cycle in place of the discarded instruction.
            if (core_reg.pf_valid)
            begin
               core_next.cur = core_reg.pf;
               core_next.pf_valid = 1'b0;
               core_next.st = ST_EXEC;
            end
            else
            begin
               core_next.st = ST_IDLE;
            end
         end
         default:
         begin
            core_next.st = ST_IDLE;
         end
      endcase

      // Instruction issue.  An idle executor starts at once; a busy one
      // holds a single prefetch, and a write beyond that is refused.
      // A write that lands in the cycle a prefetch is dropped is kept,
      // since it was fetched after the transfer and is still valid.
      if (instr_wr)
      begin
         if (core_next.st == ST_IDLE)
         begin
            core_next.cur = decode(rg.wdata);
            core_next.st = ST_EXEC;
         end
         else if (!core_next.pf_valid)
         begin
            core_next.pf = decode(rg.wdata);
            core_next.pf_valid = 1'b1;
         end
      end
   end

   // -------------------------------------------------------------------
   // State register
   // -------------------------------------------------------------------

   // Synchronous reset clears control state and the data registers.
   always_ff @(posedge CLK_I)
   begin
      if (!RST_N_I)
      begin
         core_reg <= '0;
         core_reg.st <= ST_IDLE;
         core_reg.pc <= PC_RST;
         core_reg.accumulator <= ACCUM_RST;
         core_reg.global_interrupt_enable <= INT_EN_RST;
      end
      else
      begin
         core_reg <= core_next;
      end
   end

   // -------------------------------------------------------------------
   // Register read-back
   // -------------------------------------------------------------------

   // Reads have no side effects; unmapped offsets read as zero.
   always_comb
   begin
      rg.rdata = 32'h0000_0000;
      unique case (rg.addr)
         OFF_INSTR:
         begin
            rg.rdata[INSTR_OP_LSB +: 3] = core_reg.cur.op;
            rg.rdata[INSTR_DEST_BIT] = core_reg.cur.dest;
            rg.rdata[9:0] = core_reg.cur.arg;
         end
         OFF_PC:
         begin
            rg.rdata[PC_W-1:0] = core_reg.pc;
         end
         OFF_ACCUM:
         begin
            rg.rdata[DATA_W-1:0] = core_reg.accumulator;
         end
         OFF_FLAGS:
         begin
            rg.rdata[FLAG_Z_BIT] = core_reg.zero;
            rg.rdata[FLAG_INT_EN_BIT] = core_reg.global_interrupt_enable;
            rg.rdata[FLAG_BUSY_BIT] = (core_reg.st != ST_IDLE);
            rg.rdata[FLAG_PF_BIT] = core_reg.pf_valid;
            rg.rdata[FLAG_DISC_BIT] = core_reg.discard;
            rg.rdata[FLAG_SP_LSB +: SP_W] = stk.level;
         end
         OFF_FADDR:
         begin
            rg.rdata[FILE_AW-1:0] = core_reg.faddr;
         end
         OFF_FDATA:
         begin
            rg.rdata[DATA_W-1:0] = core_reg.file[core_reg.faddr];
         end
         default:
         begin
            rg.rdata = 32'h0000_0000;
         end
      endcase
   end

   // -------------------------------------------------------------------
   // Outputs
   // -------------------------------------------------------------------

   // Architectural state straight from the state register.
   assign PC_O = core_reg.pc;
   assign ACCUMULATOR_O = core_reg.accumulator;
   assign ZERO_O = core_reg.zero;
   assign GLOBAL_INTERRUPT_ENABLE_O = core_reg.global_interrupt_enable;
   assign BUSY_O = (core_reg.st != ST_IDLE);

endmodule : branch_move_return_exec

// ===== core/exec_ifs.sv
// Carriers between the executor and its two helper modules.
// Assumes exec_pkg has been compiled first.
interface stack_if;
   import exec_pkg::*;
   logic push;                 // Push the return address this cycle.
   logic pop;                  // Pop the top entry this cycle.
   logic [PC_W-1:0] push_pc;   // Address to push.
   logic [PC_W-1:0] top_pc;    // Current top entry.
   logic [SP_W-1:0] level;     // Current stack pointer.
   modport owner (input push, input pop, input push_pc, output top_pc, output level);
   modport user (output push, output pop, output push_pc, input top_pc, input level);
endinterface : stack_if

interface reg_if;
   import exec_pkg::*;
   logic wr;                   // One-cycle write strobe.
   logic [APB_AW-1:0] addr;    // Register offset.
   logic [31:0] wdata;         // Write data.
   logic [31:0] rdata;         // Read data for addr.
   modport bus (output wr, output addr, output wdata, input rdata);
   modport regs (input wr, input addr, input wdata, output rdata);
endinterface : reg_if

// ===== core/exec_pkg.sv
// Shared constants and types for the branch, move and return executor.
// Assumes a single 100 MHz core clock and a synchronous active-low reset.
package exec_pkg;

   // -------------------------------------------------------------------
   // Widths and depths
   // -------------------------------------------------------------------
   localparam int unsigned PC_W = 10;     // Program counter width.
   localparam int unsigned DATA_W = 8;    // Data path width.
   localparam int unsigned FILE_AW = 6;   // Data register address width.
   localparam int unsigned FILE_N = 64;   // Number of data registers.
   localparam int unsigned STACK_N = 8;   // Return stack levels.
   localparam int unsigned SP_W = 3;      // Return stack pointer width.
   localparam int unsigned APB_AW = 8;    // APB address width.

   // -------------------------------------------------------------------
   // Register offsets (byte addresses)
   // -------------------------------------------------------------------
   localparam logic [7:0] OFF_INSTR = 8'h00;   // Instruction issue.
   localparam logic [7:0] OFF_PC = 8'h04;      // Program counter.
   localparam logic [7:0] OFF_ACCUM = 8'h08;   // Accumulator.
   localparam logic [7:0] OFF_FLAGS = 8'h0C;   // Flags and status.
   localparam logic [7:0] OFF_FADDR = 8'h10;   // Data register pointer.
   localparam logic [7:0] OFF_FDATA = 8'h14;   // Data register window.

   // -------------------------------------------------------------------
   // Field positions
   // -------------------------------------------------------------------
   localparam int unsigned INSTR_OP_LSB = 16;  // Opcode field, 3 bits.
   localparam int unsigned INSTR_DEST_BIT = 12; // Destination select.
   localparam int unsigned FLAG_Z_BIT = 0;     // Zero flag.
   localparam int unsigned FLAG_INT_EN_BIT = 1; // Global interrupt enable.
   localparam int unsigned FLAG_BUSY_BIT = 2;  // Executor busy.
   localparam int unsigned FLAG_PF_BIT = 3;    // Prefetch slot held.
   localparam int unsigned FLAG_DISC_BIT = 4;  // Sticky: prefetch discarded.
   localparam int unsigned FLAG_SP_LSB = 8;    // Stack pointer, 3 bits.

   // -------------------------------------------------------------------
   // Values after reset
   // -------------------------------------------------------------------
   localparam logic [PC_W-1:0] PC_RST = 10'h000;
   localparam logic [DATA_W-1:0] ACCUM_RST = 8'h00;
   localparam logic INT_EN_RST = 1'b0;

   // Opcode codes as they appear in the instruction issue register.
   typedef enum logic [2:0] {
      OP_NOP = 3'h0,
      OP_CALL_LONG = 3'h1,
      OP_JUMP_LONG = 3'h2,
      OP_LOAD_IMMEDIATE_ACC = 3'h3,
      OP_STORE_ACC_TO_FILE = 3'h4,
      OP_MOVE_FILE = 3'h5,
      OP_RETURN_WITH_LITERAL = 3'h6,
      OP_RSVD = 3'h7
   } op_t;

   // Executor sequence.
   typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_FLUSH} exec_state_t;

   // True for the control transfers that need a flush cycle.
   function automatic logic is_two_cycle(input op_t op);
      return (op == OP_CALL_LONG) || (op == OP_JUMP_LONG) ||
             (op == OP_RETURN_WITH_LITERAL);
   endfunction : is_two_cycle

   // True for an offset that holds a register.
   function automatic logic reg_mapped(input logic [APB_AW-1:0] a);
      return (a == OFF_INSTR) || (a == OFF_PC) || (a == OFF_ACCUM) ||
             (a == OFF_FLAGS) || (a == OFF_FADDR) || (a == OFF_FDATA);
   endfunction : reg_mapped

endpackage : exec_pkg

// ===== core/return_stack.sv
// Circular hardware return stack for the executor.
// Assumes push and pop are never asserted together.
module return_stack
   import exec_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_n_i,
   stack_if.owner st
);

   // All state of the stack in one record.
   typedef struct packed {
      logic [STACK_N-1:0][PC_W-1:0] mem; // Stored return addresses.
      logic [SP_W-1:0] sp;               // Next free slot.
   } stack_state_t;

   stack_state_t cur_reg;
   stack_state_t cur_next;

   // Push writes the free slot and moves up; pop moves down.
   // Overflow and underflow wrap, as a small stack would in silicon.
   always_comb
   begin
      cur_next = cur_reg;
      if (st.push)
      begin
         cur_next.mem[cur_reg.sp] = st.push_pc;
         cur_next.sp = cur_reg.sp + 3'h1;
      end
      else if (st.pop)
      begin
         cur_next.sp = cur_reg.sp - 3'h1;
      end
   end

   // State register.
   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         cur_reg <= '0;
      end
      else
      begin
         cur_reg <= cur_next;
      end
   end

   // The top is the slot just below the pointer.
   assign st.top_pc = cur_reg.mem[cur_reg.sp - 3'h1];
   assign st.level = cur_reg.sp;

endmodule : return_stack

// ===== dv/branch_move_return_exec_test.sv
// Self-checking bench: instruction table first, then hand-written cases.
// Assumes the package, design, program memory and checker compile first.
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin miscompares++; \
   $display("[ERR] %s expected %h seen %h", nm, ex, got); end end
module branch_move_return_exec_test
   import exec_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   // Expected state after each table row.
   typedef struct packed {logic [9:0] pc; logic [7:0] acc; logic z; logic ie;
      logic [2:0] sp;} row_t;
   row_t rows [8] = '{'{10'h001, 8'hA5, 1'h0, 1'h0, 3'h0}, '{10'h002, 8'hA5, 1'h0, 1'h0, 3'h0},
      '{10'h003, 8'h00, 1'h1, 1'h0, 3'h0}, '{10'h004, 8'h00, 1'h0, 1'h0, 3'h0},
      '{10'h3FF, 8'h00, 1'h0, 1'h0, 3'h1}, '{10'h000, 8'h00, 1'h0, 1'h0, 3'h1},
      '{10'h005, 8'h5A, 1'h0, 1'h1, 3'h0}, '{10'h200, 8'h5A, 1'h0, 1'h1, 3'h0}};
   logic clk = 1'h0, rst_n = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
   logic [7:0] paddr = 8'h00, acc;
   logic [31:0] pwdata = 32'h0, prdata, word, q;
   logic pready, err, pslverr, zero, ie, busy;
   logic [9:0] pc;
   logic [2:0] idx = 3'h0;
   int miscompares = 0, cmp_count = 0;
   always #5 clk = ~clk;
   branch_move_return_exec u_dut (.CLK_I(clk), .RST_N_I(rst_n), .PSEL_I(psel),
      .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata),
      .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr), .PC_O(pc),
      .ACCUMULATOR_O(acc), .ZERO_O(zero), .GLOBAL_INTERRUPT_ENABLE_O(ie), .BUSY_O(busy));
   prog_mem u_mem (.idx_i(idx), .word_o(word));
   // -------------------------------------------------------------------
   // Tasks
   // -------------------------------------------------------------------
   task automatic end_sim;
      $display("compares %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : end_sim
   // One APB transfer; the request is held until pready is seen at an edge.
   // It is called right after an edge and lets one edge pass after release.
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'h1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'h1;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (pready !== 1'h1 && n < 20);
      if (pready !== 1'h1)
      begin
         miscompares++;
         end_sim();
      end
      q = prdata;
      err = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      @(posedge clk);
   endtask : apb
   // Bounded wait for the executor to go idle.
   task automatic idle;
      int n;
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (busy !== 1'h0 && n < 10);
      if (busy !== 1'h0)
      begin
         miscompares++;
         end_sim();
      end
   endtask : idle
   // -------------------------------------------------------------------
   // Main sequence
   // -------------------------------------------------------------------
   initial
   begin
      repeat (4) @(posedge clk);
      rst_n <= 1'h1;
      @(posedge clk);
      for (int i = 0; i < 8; i++)
      begin
         idx <= i[2:0];
         @(posedge clk);
         apb(1'h1, OFF_INSTR, word);
         idle();
         `CHK("pc", rows[i].pc, pc)
         `CHK("accumulator", rows[i].acc, acc)
         `CHK("zero", rows[i].z, zero)
         `CHK("int enable", rows[i].ie, ie)
         apb(1'h0, OFF_FLAGS, 32'h0);
         `CHK("stack level", rows[i].sp, q[10:8])
         $display("row %0d done", i);
      end
      // The stored register is read back through the pointer and window.
      apb(1'h1, OFF_FADDR, 32'h0000003F);
      apb(1'h0, OFF_FDATA, 32'h0);
      `CHK("register 63", 8'hA5, q[7:0])
      apb(1'h0, 8'h18, 32'h0);
      `CHK("unmapped error", 1'h1, err)
      `CHK("unmapped data", 32'h0, q)
      $display("register tests done");
      // A second reset in mid-run must clear the visible state.
      rst_n <= 1'h0;
      repeat (2) @(posedge clk);
      rst_n <= 1'h1;
      @(posedge clk);
      #1;
      `CHK("reset pc", 10'h000, pc)
      `CHK("reset accumulator", 8'h00, acc)
      `CHK("reset int enable", 1'h0, ie)
      $display("reset test done");
      end_sim();
   end
   // Watchdog: a hang counts as a mismatch.
   initial
   begin
      repeat (5000) @(posedge clk);
      miscompares++;
      end_sim();
   end
endmodule : branch_move_return_exec_test

// ===== dv/exec_checker.sv
// Port assertions for the branch, move and return executor.
// Assumes the bench issues a new instruction only while BUSY_O is low.
module exec_checker
   import exec_pkg::*;
(
   input wire logic CLK_I,
   input wire logic RST_N_I,
   input wire logic PSEL_I,
   input wire logic PENABLE_I,
   input wire logic PWRITE_I,
   input wire logic [APB_AW-1:0] PADDR_I,
   input wire logic [31:0] PWDATA_I,
   input wire logic [PC_W-1:0] PC_O,
   input wire logic [DATA_W-1:0] ACCUMULATOR_O,
   input wire logic ZERO_O,
   input wire logic GLOBAL_INTERRUPT_ENABLE_O,
   input wire logic BUSY_O
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge CLK_I); endclocking
   default disable iff (!RST_N_I);
   // -------------------------------------------------------------------
   // Issue decode
   // -------------------------------------------------------------------
   logic go; // An instruction taken by an idle executor.
   logic [2:0] op; // Its opcode field.
   assign go = PSEL_I && PENABLE_I && PWRITE_I && (PADDR_I == OFF_INSTR) && !BUSY_O;
   assign op = PWDATA_I[18:16];
   // Effects land after the second edge, so each effect check looks two edges on; the length checks follow BUSY_O edge by edge.
   imm_load_a: assert property (
      go && op == 3'h3 |-> ##2 ACCUMULATOR_O == $past(PWDATA_I[7:0], 2)
      && ZERO_O == $past(ZERO_O, 2)) else $error("immediate load wrong");
   target_load_a: assert property (
      go && (op == 3'h1 || op == 3'h2) |-> ##2 PC_O == $past(PWDATA_I[9:0], 2))
      else $error("target not loaded");
   ret_literal_a: assert property (
      go && op == 3'h6 |-> ##2 GLOBAL_INTERRUPT_ENABLE_O
      && ACCUMULATOR_O == $past(PWDATA_I[7:0], 2)) else $error("return wrong");
   nop_advance_a: assert property (
      go && op == 3'h0 |-> ##2 PC_O == $past(PC_O, 2) + 10'h001
      && ACCUMULATOR_O == $past(ACCUMULATOR_O, 2)) else $error("no-op wrong");
   flush_cycle_a: assert property (
      go && (op == 3'h1 || op == 3'h2 || op == 3'h6) |-> ##1 BUSY_O [*2] ##1 !BUSY_O)
      else $error("transfer length wrong");
   single_cycle_a: assert property (
      go && (op == 3'h0 || op == 3'h3 || op == 3'h4 || op == 3'h5)
      |-> ##1 BUSY_O ##1 !BUSY_O) else $error("single op length wrong");
   move_zero_a: assert property (
      go && op == 3'h5 && !PWDATA_I[12] |-> ##2 ZERO_O == (ACCUMULATOR_O == 8'h00))
      else $error("move zero flag wrong");
   acc_kept_a: assert property (
      go && (op == 3'h4 || (op == 3'h5 && PWDATA_I[12]))
      |-> ##2 ACCUMULATOR_O == $past(ACCUMULATOR_O, 2)) else $error("accumulator changed");
endmodule : exec_checker
bind branch_move_return_exec exec_checker u_chk (.CLK_I(CLK_I), .RST_N_I(RST_N_I),
   .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I),
   .PWDATA_I(PWDATA_I), .PC_O(PC_O), .ACCUMULATOR_O(ACCUMULATOR_O), .ZERO_O(ZERO_O),
   .GLOBAL_INTERRUPT_ENABLE_O(GLOBAL_INTERRUPT_ENABLE_O), .BUSY_O(BUSY_O));

// ===== dv/prog_mem.sv
// Program memory model: the instruction words fed to the executor.
// Assumes the bench steps the index from 0 to 7, one word per step.
module prog_mem
(
   input wire logic [2:0] idx_i,
   output logic [31:0] word_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // Opcode in bits 18:16, destination in bit 12, operand below it.
   always_comb
   begin
      case (idx_i)
         3'h0: word_o = 32'h000300A5; // Immediate load.
         3'h1: word_o = 32'h0004003F; // Store to the top register.
         3'h2: word_o = 32'h00050005; // Move a zero register to the accumulator.
         3'h3: word_o = 32'h0005103F; // Move a register back onto itself.
         3'h4: word_o = 32'h000103FF; // Call to the last address.
         3'h5: word_o = 32'h00000000; // No-op; the counter wraps to zero.
         3'h6: word_o = 32'h0006005A; // Return with a literal.
         default: word_o = 32'h00020200; // Jump.
      endcase
   end
endmodule : prog_mem
